// ==== hdl/smf_fifo.sv ====
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes a single clock; ready on the write side is registered.
 */
`timescale 1ns/100ps
module smf_fifo #(
	parameter int W = 32,
	parameter int D = 32
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         wr_valid_in,
	input  wire logic [W-1:0] wr_data_in,
	output logic              wr_ready_out,
	output logic              rd_valid_out,
	output logic [W-1:0]      rd_data_out,
	input  wire logic         rd_ready_in
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp, rp, next_wp, next_rp;
	logic [CW-1:0] cnt, next_cnt;
	logic          space, next_space;
	logic          do_wr, do_rd;

	always_comb begin
		do_wr     = wr_valid_in && space;
		do_rd     = rd_ready_in && (cnt != '0);
		next_wp   = do_wr ? ((wp == AW'(D - 1)) ? '0 : wp + 1'b1) : wp;
		next_rp   = do_rd ? ((rp == AW'(D - 1)) ? '0 : rp + 1'b1) : rp;
		next_cnt  = cnt + CW'(do_wr) - CW'(do_rd);
		next_space = (next_cnt != CW'(D));
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wp   <= '0;
			rp   <= '0;
			cnt  <= '0;
			space <= 1'b1;
		end else begin
			wp   <= next_wp;
			rp   <= next_rp;
			cnt  <= next_cnt;
			space <= next_space;
		end
	end

	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem[wp] <= wr_data_in;
		end
	end

	assign wr_ready_out = space;
	assign rd_valid_out = (cnt != '0);
	assign rd_data_out  = mem[rp];
endmodule : smf_fifo

// ==== hdl/smf_pkg.sv ====
/*
 * constants, config carrier and state type for the four-select serial master.
 * assumes one system clock; all config comes from same-clock logic.
 */
// Contract
// RULE1: each character shifts in and out together, 1 to 32 bits long.
// RULE2: master only; the block generates the serial clock itself.
// RULE3: four chip-select outputs, exactly one asserted at a time; the code asserts none while idle.
// RULE4: no dma request path; characters move through cpu-fed ports only.
// RULE5: a frame holds 1 to 4096 characters.
// RULE6: optional pulse on every character completion, none when disabled.
// RULE7: extra 0 to 3 serial clock cycles between select and first edge.
// RULE8: each chip select has its own programmable active level.
// RULE9: per select, polarity and phase choose transfer modes 0 to 3.
// RULE10: mode 0 samples on rising edge, changes output after falling edge.
// RULE11: mode 1 drives output after rising edge, samples on falling edge.
// RULE12: mode 3 drives output after falling edge, samples on rising edge.
// RULE13: serial clock from divider, period never below four system clocks.
// RULE14: loopback feeds transmitted stream back into the receive path.
// RULE15: select held across whole frame, released after last clock edge.
package smf_pkg;
	localparam int          CHAR_W      = 32;
	localparam int          LEN_W       = 5;
	localparam int          FRAME_W     = 12;
	localparam int          CS_N        = 4;
	localparam int          CS_SEL_W    = 2;
	localparam int          DLY_W       = 2;
	localparam int          DIV_W       = 16;
	localparam int          FIFO_DEPTH  = 32;
	localparam int          MIN_PER_SYS = 4;
	localparam logic [DIV_W-1:0] MIN_HALF = DIV_W'(MIN_PER_SYS / 2);
	localparam logic [2:0]  LEAD_BASE   = 3'h1;
	localparam logic [2:0]  TAIL_HALF   = 3'h1;

	typedef struct packed {
		logic [LEN_W-1:0]   len_m1;
		logic [FRAME_W-1:0] frame_m1;
		logic [DIV_W-1:0]   half_div;
		logic [CS_SEL_W-1:0] cs_sel;
		logic [CS_N-1:0]    cs_pol;
		logic [CS_N-1:0]    cpol;
		logic [CS_N-1:0]    cpha;
		logic [DLY_W-1:0]   cs_delay;
		logic               loopback;
		logic               char_irq_en;
	} smf_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LEAD,
		ST_LOAD,
		ST_SHIFT,
		ST_TAIL
	} smf_state_t;
endpackage : smf_pkg

// ==== hdl/smf_spi_master.sv ====
/*
 * four-select serial master: divider, frame sequencer, shifter, tx fifo.
 * assumes config and tx stream come from same-clock cpu logic; miso is a pin.
 */
`timescale 1ns/100ps
module smf_spi_master #(
	parameter int FIFO_D = smf_pkg::FIFO_DEPTH
) (
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	input  wire smf_pkg::smf_cfg_t             cfg_in,
	input  wire logic                          start_in,
	input  wire logic                          tx_valid_in,
	input  wire logic [smf_pkg::CHAR_W-1:0]    tx_data_in,
	output logic                               tx_ready_out,
	output logic                               rx_valid_out,
	output logic [smf_pkg::CHAR_W-1:0]         rx_data_out,
	output logic                               char_irq_out,
	output logic                               frame_done_out,
	output logic                               busy_out,
	output logic                               sclk_out,
	output logic                               mosi_out,
	input  wire logic                          miso_in,
	output logic [smf_pkg::CS_N-1:0]           slave_select_n_out
);
	import smf_pkg::*;

	smf_state_t        state, next_state;
	smf_cfg_t          cfg, next_cfg;
	logic [DIV_W-1:0]  div_cnt, next_div_cnt, half;
	logic [2:0]        lead_cnt, next_lead_cnt;
	logic [LEN_W:0]    edge_cnt, next_edge_cnt;
	logic [FRAME_W-1:0] chars_left, next_chars_left;
	logic [CHAR_W-1:0] tx_sreg, next_tx_sreg, rx_sreg, next_rx_sreg;
	logic [CHAR_W-1:0] rx_data, next_rx_data;
	logic              sclk, next_sclk, mosi, next_mosi;
	logic              cs_on, next_cs_on;
	logic              rx_valid, next_rx_valid, irq, next_irq;
	logic              fdone, next_fdone, busy, next_busy;
	logic [CS_N-1:0]   cs_pins, next_cs_pins;
	logic              miso_s1, miso_s2;
	logic              tick, sel_cpol, sel_cpha, in_bit, lead_edge, last_edge;
	logic              fifo_valid, fifo_pop, tx_ready;
	logic [CHAR_W-1:0] fifo_data;

	// tx words come only from the cpu-side stream port
	smf_fifo #(.W(CHAR_W), .D(FIFO_D)) u_tx_fifo ( // RULE4
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.wr_valid_in  (tx_valid_in),
		.wr_data_in   (tx_data_in),
		.wr_ready_out (tx_ready),
		.rd_valid_out (fifo_valid),
		.rd_data_out  (fifo_data),
		.rd_ready_in  (fifo_pop)
	);

	// pin synchroniser
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			miso_s1 <= 1'b0;
			miso_s2 <= 1'b0;
		end else begin
			miso_s1 <= miso_in;
			miso_s2 <= miso_s1;
		end
	end

	always_comb begin
		// clamp half period so the full period is at least four clocks
		half      = (cfg.half_div < MIN_HALF) ? MIN_HALF : cfg.half_div; // RULE13
		tick      = (div_cnt == '0);
		sel_cpol  = cfg.cpol[cfg.cs_sel]; // RULE9
		sel_cpha  = cfg.cpha[cfg.cs_sel]; // RULE9
		in_bit    = cfg.loopback ? mosi : miso_s2; // RULE14
		lead_edge = !edge_cnt[0];
		last_edge = (edge_cnt == {cfg.len_m1, 1'b1}); // RULE1

		next_state      = state;
		next_cfg        = cfg;
		next_div_cnt    = (div_cnt == '0) ? half - 1'b1 : div_cnt - 1'b1;
		next_lead_cnt   = lead_cnt;
		next_edge_cnt   = edge_cnt;
		next_chars_left = chars_left;
		next_tx_sreg    = tx_sreg;
		next_rx_sreg    = rx_sreg;
		next_rx_data    = rx_data;
		next_sclk       = sclk;
		next_mosi       = mosi;
		next_cs_on      = cs_on;
		next_rx_valid   = 1'b0;
		next_irq        = 1'b0;
		next_fdone      = 1'b0;
		next_busy       = busy;
		fifo_pop        = 1'b0;

		case (state)
			ST_IDLE: begin
				next_cfg     = cfg_in;
				next_sclk    = cfg_in.cpol[cfg_in.cs_sel];
				next_div_cnt = '0;
				if (start_in) begin
					next_busy       = 1'b1;
					next_cs_on      = 1'b1; // RULE3
					next_chars_left = cfg_in.frame_m1; // RULE5
					// half period base plus whole extra cycles
					next_lead_cnt   = LEAD_BASE + {cfg_in.cs_delay, 1'b0}; // RULE7
					next_div_cnt    = (cfg_in.half_div < MIN_HALF) ?
						MIN_HALF - 1'b1 : cfg_in.half_div - 1'b1;
					next_state      = ST_LEAD;
				end
			end
			ST_LEAD: begin
				if (tick) begin
					next_lead_cnt = lead_cnt - 1'b1;
					if (lead_cnt == 3'h1) begin
						next_state = ST_LOAD;
					end
				end
			end
			ST_LOAD: begin
				next_div_cnt = half - 1'b1;
				if (fifo_valid) begin
					fifo_pop      = 1'b1;
					next_edge_cnt = '0;
					next_rx_sreg  = '0;
					next_tx_sreg  = fifo_data;
					if (!sel_cpha) begin
						// phase 0 presents the first bit before the first edge
						next_mosi    = fifo_data[cfg.len_m1]; // RULE10
						next_tx_sreg = fifo_data << 1;
					end
					next_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (tick) begin
					next_sclk     = sel_cpol ^ lead_edge; // RULE2 RULE9
					next_edge_cnt = edge_cnt + 1'b1;
					if (lead_edge ^ sel_cpha) begin
						// sampling edge
						next_rx_sreg = {rx_sreg[CHAR_W-2:0], in_bit}; // RULE1 RULE10 RULE11 RULE12
					end else if (!last_edge) begin
						// driving edge
						next_mosi    = tx_sreg[cfg.len_m1]; // RULE10 RULE11 RULE12
						next_tx_sreg = tx_sreg << 1;
					end
					if (last_edge) begin
						next_rx_valid = 1'b1;
						next_rx_data  = sel_cpha ? {rx_sreg[CHAR_W-2:0], in_bit} : rx_sreg;
						next_irq      = cfg.char_irq_en; // RULE6
						if (chars_left == '0) begin
							next_lead_cnt = TAIL_HALF;
							next_state    = ST_TAIL;
						end else begin
							// select stays asserted between characters
							next_chars_left = chars_left - 1'b1; // RULE15
							next_state      = ST_LOAD;
						end
					end
				end
			end
			ST_TAIL: begin
				if (tick) begin
					next_lead_cnt = lead_cnt - 1'b1;
					if (lead_cnt == 3'h1) begin
						next_cs_on = 1'b0; // RULE15
						next_fdone = 1'b1;
						next_busy  = 1'b0;
						next_state = ST_IDLE;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cs_on = 1'b0;
				next_busy  = 1'b0;
			end
		endcase
	end

	// per-select pin level from its programmed polarity
	for (genvar i = 0; i < CS_N; i++) begin : g_cs
		always_comb begin
			if (next_cs_on && (next_cfg.cs_sel == CS_SEL_W'(i))) begin
				next_cs_pins[i] = next_cfg.cs_pol[i]; // RULE3 RULE8
			end else begin
				next_cs_pins[i] = !next_cfg.cs_pol[i]; // RULE8
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state      <= ST_IDLE;
			cfg        <= '0;
			div_cnt    <= '0;
			lead_cnt   <= '0;
			edge_cnt   <= '0;
			chars_left <= '0;
			tx_sreg    <= '0;
			rx_sreg    <= '0;
			rx_data    <= '0;
			sclk       <= 1'b0;
			mosi       <= 1'b0;
			cs_on      <= 1'b0;
			rx_valid   <= 1'b0;
			irq        <= 1'b0;
			fdone      <= 1'b0;
			busy       <= 1'b0;
			cs_pins    <= '1;
		end else begin
			state      <= next_state;
			cfg        <= next_cfg;
			div_cnt    <= next_div_cnt;
			lead_cnt   <= next_lead_cnt;
			edge_cnt   <= next_edge_cnt;
			chars_left <= next_chars_left;
			tx_sreg    <= next_tx_sreg;
			rx_sreg    <= next_rx_sreg;
			rx_data    <= next_rx_data;
			sclk       <= next_sclk;
			mosi       <= next_mosi;
			cs_on      <= next_cs_on;
			rx_valid   <= next_rx_valid;
			irq        <= next_irq;
			fdone      <= next_fdone;
			busy       <= next_busy;
			cs_pins    <= next_cs_pins;
		end
	end

	assign tx_ready_out       = tx_ready;
	assign rx_valid_out       = rx_valid;
	assign rx_data_out        = rx_data;
	assign char_irq_out       = irq;
	assign frame_done_out     = fdone;
	assign busy_out           = busy;
	assign sclk_out           = sclk;
	assign mosi_out           = mosi;
	assign slave_select_n_out = cs_pins;
endmodule : smf_spi_master

// ==== tb/smf_slave_model.sv ====
/*
 * behavioural serial slave for the four-select master.
 * assumes the bench works out select, polarity and phase of the selected slave.
 */
`timescale 1ns/100ps
module smf_slave_model (
	input  wire logic        sclk_in,
	input  wire logic        mosi_in,
	input  wire logic        sel_in,
	input  wire logic        cpol_in,
	input  wire logic        cpha_in,
	input  wire logic [4:0]  len_in,
	input  wire logic [31:0] word_in,
	output logic             miso_out,
	output logic [31:0]      rx_out
);
	int idx;
	task automatic drive;
		if (idx >= 0)
			miso_out = word_in[len_in - 5'(idx % (int'(len_in) + 1))];
	endtask : drive
	initial miso_out = 1'b0;
	always @(posedge sel_in) begin
		idx = cpha_in ? -1 : 0; // phase 1 shows its first bit at the leading edge
		rx_out = 32'h0;
		drive();
	end
	always @(negedge sel_in) miso_out = ~miso_out; // released line keeps no value
	always @(sclk_in) begin
		if (sel_in && ((sclk_in != cpol_in) == !cpha_in)) begin
			rx_out = {rx_out[30:0], mosi_in};
		end else if (sel_in) begin
			idx = idx + 1;
			drive();
		end
	end
endmodule : smf_slave_model

// ==== tb/smf_spi_master_assertions.sv ====
/*
 * port assertions for the four-select serial master.
 * assumes cfg_in stays steady while a frame runs.
 */
`timescale 1ns/100ps
module smf_spi_master_assertions (
	input wire logic                       clk_in,
	input wire logic                       rst_in,
	input wire smf_pkg::smf_cfg_t          cfg_in,
	input wire logic                       start_in,
	input wire logic                       rx_valid_out,
	input wire logic [smf_pkg::CHAR_W-1:0] rx_data_out,
	input wire logic                       char_irq_out,
	input wire logic                       frame_done_out,
	input wire logic                       busy_out,
	input wire logic                       sclk_out,
	input wire logic [smf_pkg::CS_N-1:0]   slave_select_n_out
);
	import smf_pkg::*;
	logic [CS_N-1:0] act;
	assign act = ~(slave_select_n_out ^ cfg_in.cs_pol);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	a_one_select: assert property (busy_out |-> $onehot(act))
		else $error("select not one-hot while busy");
	a_cs_hold: assert property (busy_out && $past(busy_out) |-> $stable(slave_select_n_out))
		else $error("select moved inside frame");
	a_cs_idle: assert property ((!busy_out && $stable(cfg_in)) [*2] |-> slave_select_n_out == ~cfg_in.cs_pol)
		else $error("idle select level wrong");
	a_sclk_idle: assert property ((!busy_out && $stable(cfg_in)) [*3] |-> sclk_out == cfg_in.cpol[cfg_in.cs_sel])
		else $error("idle clock level wrong");
	a_sclk_min: assert property ($changed(sclk_out) |=> $stable(sclk_out))
		else $error("clock half period below two clocks");
	a_irq_pair: assert property (char_irq_out |-> rx_valid_out && cfg_in.char_irq_en)
		else $error("stray char interrupt");
	a_irq_each: assert property (rx_valid_out && cfg_in.char_irq_en |-> char_irq_out)
		else $error("missing char interrupt");
	a_rx_pulse: assert property (rx_valid_out |=> !rx_valid_out)
		else $error("rx valid longer than one cycle");
	a_rx_width: assert property (rx_valid_out |-> (rx_data_out >> ({1'b0, cfg_in.len_m1} + 6'h01)) == '0)
		else $error("rx bits above char length");
	a_done_end: assert property (frame_done_out |-> !busy_out && $past(busy_out))
		else $error("frame done without frame end");
	a_busy_start: assert property (start_in && !busy_out |=> busy_out)
		else $error("start not taken");
endmodule : smf_spi_master_assertions
bind smf_spi_master smf_spi_master_assertions u_smf_spi_master_assertions (.clk_in(clk_in),
	.rst_in(rst_in), .cfg_in(cfg_in), .start_in(start_in), .rx_valid_out(rx_valid_out),
	.rx_data_out(rx_data_out), .char_irq_out(char_irq_out), .frame_done_out(frame_done_out),
	.busy_out(busy_out), .sclk_out(sclk_out), .slave_select_n_out(slave_select_n_out));

// ==== tb/smf_spi_master_tb.sv ====
/*
 * bench: frames in all modes, loopback, fifo fill and drain.
 * assumes the slave model and the bound checker.
 */
`timescale 1ns/100ps
module smf_spi_master_tb;
	import smf_pkg::*;
	logic        clk_in, rst_in, start_in, tx_valid_in, miso, sel, ready, busy, sclk, mosi;
	logic        rxv, irq, done, ok;
	logic [31:0] tx_data, rx_data, srx, tw, sw;
	logic [3:0]  ssn;
	logic [4:0]  lens [4] = '{5'h00, 5'h07, 5'h14, 5'h1F};
	smf_cfg_t    cfg;
	int          miscompares, samples_checked, n;

	smf_spi_master u_smf_spi_master (.clk_in(clk_in), .rst_in(rst_in), .cfg_in(cfg),
		.start_in(start_in), .tx_valid_in(tx_valid_in), .tx_data_in(tx_data),
		.tx_ready_out(ready), .rx_valid_out(rxv), .rx_data_out(rx_data), .char_irq_out(irq),
		.frame_done_out(done), .busy_out(busy), .sclk_out(sclk), .mosi_out(mosi),
		.miso_in(miso), .slave_select_n_out(ssn));
	assign sel = (ssn[cfg.cs_sel] == cfg.cs_pol[cfg.cs_sel]);
	smf_slave_model u_smf_slave_model (.sclk_in(sclk), .mosi_in(mosi), .sel_in(sel),
		.cpol_in(cfg.cpol[cfg.cs_sel]), .cpha_in(cfg.cpha[cfg.cs_sel]), .len_in(cfg.len_m1),
		.word_in(sw), .miso_out(miso), .rx_out(srx));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask : tick

	task automatic push(input int cnt, input int lim);
		n = 0;
		tx_valid_in = 1'b1;
		tx_data = tw;
		for (int t = 0; t < lim && n < cnt; t++) begin
			ok = ready;
			tick();
			n += int'(ok);
		end
		tx_valid_in = 1'b0;
	endtask : push

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	task automatic run_frame(input logic [1:0] cs, md, dly, input logic [4:0] ln, input int nc,
		input int np, input logic [15:0] hd, input logic ie, lb);
		logic [31:0] mask, want;
		logic [3:0]  sv;
		int          nrx, nirq, h;
		mask = 32'hFFFF_FFFF >> (5'h1F - ln);
		h = (hd < 2) ? 2 : int'(hd);
		cfg.cs_sel = cs;
		cfg.cpol[cs] = md[1];
		cfg.cpha[cs] = md[0];
		cfg.cs_pol[cs] = cs[0];
		cfg.len_m1 = ln;
		cfg.frame_m1 = 12'(nc - 1);
		cfg.cs_delay = dly;
		cfg.half_div = hd;
		cfg.char_irq_en = ie;
		cfg.loopback = lb;
		if (np > 0)
			push(np, 1000);
		want = lb ? (tw & mask) : (sw & mask);
		sv = ~cfg.cs_pol;
		sv[cs] = cs[0];
		start_in = 1'b1;
		tick();
		start_in = 1'b0;
		while (busy !== 1'b1)
			tick();
		n = 0;
		while (sclk === md[1]) begin
			tick();
			n++;
		end
		chk(32'(n), 32'((2 + 2 * dly) * h + 1), "lead");
		chk({28'h0, ssn}, {28'h0, sv}, "selects");
		nrx = 0;
		nirq = 0;
		while (busy === 1'b1) begin
			if (rxv === 1'b1) begin
				nrx++;
				chk(rx_data, want, "rx char");
			end
			nirq += int'(irq === 1'b1);
			tick();
		end
		chk(32'(done), 32'h1, "frame done");
		chk(32'(nrx), 32'(nc), "chars");
		chk(32'(nirq), ie ? 32'(nc) : 32'h0, "irqs");
		chk(srx & mask, tw & mask, "slave rx");
		chk({28'h0, ssn}, {28'h0, ~cfg.cs_pol}, "release");
		$display("frame cs %0d mode %0d len %0d done", cs, md, ln + 1);
	endtask : run_frame

	initial begin
		miscompares = 0;
		samples_checked = 0;
		cfg = '0;
		start_in = 1'b0;
		tx_valid_in = 1'b0;
		tx_data = 32'h0;
		tw = 32'h5A3C_96E1;
		sw = 32'hC3A5_1E69;
		rst_in = 1'b1;
		repeat (8) tick();
		chk({28'h0, ssn}, 32'hF, "reset selects");
		chk(32'(ready), 32'h1, "reset ready");
		$display("reset test done");
		rst_in = 1'b0;
		tick();
		for (int i = 0; i < 4; i++)
			run_frame(2'(i), 2'(i), 2'(i), lens[i], i + 1, i + 1, 16'(i + 3), i[0], 1'b0);
		run_frame(2'h1, 2'h3, 2'h0, 5'h0F, 2, 2, 16'h3, 1'b1, 1'b1);
		push(40, 40);
		chk(32'(n), 32'(FIFO_DEPTH), "fifo fill");
		run_frame(2'h2, 2'h0, 2'h3, 5'h00, 32, 0, 16'h1, 1'b0, 1'b1);
		chk(32'(ready), 32'h1, "fifo drained");
		$display("fifo test done");
		finish_test();
	end

	initial begin
		#(20000 * 50);
		miscompares++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule : smf_spi_master_tb
